// >>> core/mb_defs.svh
// protocol constants shared by both ends of the serial query link
`ifndef MB_DEFS_SVH
`define MB_DEFS_SVH
`define FN_DIAG 8'h08
`define FN_WRITE_MULTI 8'h10
`define FN_EXC_FLAG 8'h80
`define EXC_BAD_FUNC 8'h01
`define EXC_BAD_ADDR 8'h02
`define EXC_BAD_VALUE 8'h03
`define STATION_BCAST 8'h00
`define SUBFN_ECHO 16'h0000
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`define DIAG_LEN 9'h008
`define WRITE_HDR_LEN 9'h009
`define REPLY_BODY_LEN 9'h006
`define EXC_BODY_LEN 9'h003
`define MIN_FRAME_LEN 9'h004
`define POS_STATION 0
`define POS_FUNC 1
`define POS_ADDR_HI 2
`define POS_ADDR_LO 3
`define POS_CNT_HI 4
`define POS_CNT_LO 5
`define POS_BYTE_CNT 6
`define POS_DATA 7
`define CLK_PERIOD_NS 25
`define BCAST_GAP_NS 100000
`define REPLY_TIMEOUT_NS 100000
`endif

// >>> core/mb_pkg.sv
// types and crc helper for the serial query link
`include "mb_defs.svh"
package mb_pkg;
  typedef enum logic [2:0] {
    DEV_RX = 3'h0,
    DEV_CHK = 3'h1,
    DEV_WR = 3'h3,
    DEV_TX = 3'h2
  } dev_state_type;

  typedef enum logic [2:0] {
    MST_IDLE = 3'h0,
    MST_TX = 3'h1,
    MST_RSP = 3'h3,
    MST_GAP = 3'h2
  } mst_state_type;

  // one byte through the reflected crc, lsb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// >>> core/mb_link_if.sv
// byte-stream link between query master and drive
`timescale 1ns/1ps
interface mb_link_if;
  logic q_valid;
  logic q_ready;
  logic [7:0] q_data;
  logic q_last;
  logic q_err;
  logic r_valid;
  logic r_ready;
  logic [7:0] r_data;
  logic r_last;

  modport dev (
    input q_valid, q_data, q_last, q_err, r_ready,
    output q_ready, r_valid, r_data, r_last
  );
  modport mst (
    output q_valid, q_data, q_last, q_err, r_ready,
    input q_ready, r_valid, r_data, r_last
  );
endinterface

// >>> core/mb_drive_end.sv
// drive end: diagnostics echo and multi-register write handling
`timescale 1ns/1ps
`include "mb_defs.svh"
module mb_drive_end #(
  parameter int MAX_FRAME = 256,
  parameter int IW = 9
) (
  input wire logic ref_clk, // 40 MHz clock
  input wire logic sys_rst, // async reset, active high
  mb_link_if.dev link, // link to the master
  input wire logic [7:0] station_id, // own station number
  output logic wr_valid, // holding register write strobe
  output logic [15:0] wr_addr, // holding register address
  output logic [15:0] wr_data, // holding register value
  input wire logic wr_accept, // register took the write
  output logic busy // query being processed
);
  mb_pkg::dev_state_type state_reg;
  logic [7:0] mem [MAX_FRAME];
  logic [IW-1:0] len_reg;
  logic [IW-1:0] idx_reg;
  logic [IW-1:0] tx_len_reg;
  logic [15:0] crc_reg;
  logic err_reg;
  logic any_ok_reg;
  logic any_ok;
  logic [15:0] wcnt_reg;
  logic [7:0] exc_code;
  logic do_exc;
  logic do_echo;
  logic do_write;
  logic bcast;
  logic drop;
  logic [15:0] start_addr;
  logic [15:0] reg_cnt;
  logic [7:0] byte_cnt;
  logic [IW-1:0] wpos;
  logic tx_step;
  logic [7:0] tx_byte;

  assign bcast = mem[`POS_STATION] == `STATION_BCAST;
  assign start_addr = {mem[`POS_ADDR_HI], mem[`POS_ADDR_LO]};
  assign reg_cnt = {mem[`POS_CNT_HI], mem[`POS_CNT_LO]};
  assign byte_cnt = mem[`POS_BYTE_CNT];
  assign wpos = IW'(`POS_DATA) + {idx_reg[IW-2:0], 1'b0};
  assign link.q_ready = state_reg == mb_pkg::DEV_RX;
  assign busy = state_reg != mb_pkg::DEV_RX;
  assign tx_step = !link.r_valid || link.r_ready;
  // the last register's acceptance arrives in the very cycle of the verdict
  assign any_ok = any_ok_reg || (wr_valid && wr_accept);

  // verdict on a complete frame, taken when the crc walk ends
  always_comb begin
    drop = err_reg || len_reg < `MIN_FRAME_LEN || crc_reg != 16'h0000;
    if (!bcast && mem[`POS_STATION] != station_id) begin
      drop = 1'b1;
    end
    if (bcast && mem[`POS_FUNC] != `FN_WRITE_MULTI) begin
      drop = 1'b1;
    end
    do_exc = 1'b0;
    do_echo = 1'b0;
    do_write = 1'b0;
    exc_code = `EXC_BAD_VALUE;
    case (mem[`POS_FUNC])
      `FN_DIAG: begin
        if (len_reg != `DIAG_LEN || {mem[`POS_ADDR_HI], mem[`POS_ADDR_LO]} != `SUBFN_ECHO) begin
          do_exc = 1'b1;
        end else begin
          do_echo = 1'b1;
        end
      end
      `FN_WRITE_MULTI: begin
        // full-width compare so a huge count cannot alias a small byte count
        if (reg_cnt == 16'h0000 || {9'h000, byte_cnt} != {reg_cnt, 1'b0}
            || len_reg != `WRITE_HDR_LEN + IW'(byte_cnt)) begin
          do_exc = 1'b1;
        end else begin
          do_write = 1'b1;
        end
      end
      default: begin
        do_exc = 1'b1;
        exc_code = `EXC_BAD_FUNC;
      end
    endcase
  end

  always_comb begin
    if (idx_reg < tx_len_reg) begin
      tx_byte = mem[idx_reg[IW-2:0]];
    end else if (idx_reg == tx_len_reg) begin
      tx_byte = crc_reg[7:0];
    end else begin
      tx_byte = crc_reg[15:8];
    end
  end

  // sequencing
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= mb_pkg::DEV_RX;
    end else begin
      case (state_reg)
        mb_pkg::DEV_RX: begin
          if (link.q_valid && link.q_last) begin
            state_reg <= mb_pkg::DEV_CHK;
          end
        end
        mb_pkg::DEV_CHK: begin
          if (idx_reg == len_reg) begin
            if (drop || (bcast && !do_write)) begin
              state_reg <= mb_pkg::DEV_RX;
            end else if (do_write) begin
              state_reg <= mb_pkg::DEV_WR;
            end else begin
              state_reg <= mb_pkg::DEV_TX;
            end
          end
        end
        mb_pkg::DEV_WR: begin
          if (wcnt_reg == reg_cnt) begin
            // no answer at all to a broadcast
            state_reg <= bcast ? mb_pkg::DEV_RX : mb_pkg::DEV_TX;
          end
        end
        mb_pkg::DEV_TX: begin
          if (link.r_valid && link.r_ready && link.r_last) begin
            state_reg <= mb_pkg::DEV_RX;
          end
        end
        default: state_reg <= mb_pkg::DEV_RX;
      endcase
    end
  end

  // frame storage; replies are built in place over the query
  always_ff @(posedge ref_clk) begin
    if (state_reg == mb_pkg::DEV_RX && link.q_valid && len_reg < IW'(MAX_FRAME)) begin
      mem[len_reg[IW-2:0]] <= link.q_data;
    end else if (state_reg == mb_pkg::DEV_CHK && idx_reg == len_reg && do_exc) begin
      mem[`POS_FUNC] <= mem[`POS_FUNC] | `FN_EXC_FLAG;
      mem[`POS_FUNC + 1] <= exc_code;
    end else if (state_reg == mb_pkg::DEV_WR && wcnt_reg == reg_cnt && !any_ok) begin
      mem[`POS_FUNC] <= mem[`POS_FUNC] | `FN_EXC_FLAG;
      mem[`POS_FUNC + 1] <= `EXC_BAD_ADDR;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      len_reg <= '0;
      err_reg <= 1'b0;
    end else if (state_reg == mb_pkg::DEV_RX && link.q_valid) begin
      len_reg <= link.q_last ? len_reg : len_reg + 1'b1;
      // oversize frames are treated like a line error
      err_reg <= err_reg || link.q_err || len_reg >= IW'(MAX_FRAME);
      if (link.q_last) begin
        len_reg <= len_reg + 1'b1;
      end
    end else if (state_reg == mb_pkg::DEV_CHK && idx_reg == len_reg) begin
      len_reg <= '0;
      err_reg <= 1'b0;
    end
  end

  // crc walk, write data pointer and transmit pointer share idx_reg
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idx_reg <= '0;
      crc_reg <= `CRC_INIT;
      tx_len_reg <= '0;
    end else begin
      case (state_reg)
        mb_pkg::DEV_RX: begin
          idx_reg <= '0;
          crc_reg <= `CRC_INIT;
        end
        mb_pkg::DEV_CHK: begin
          if (idx_reg == len_reg) begin
            idx_reg <= '0;
            crc_reg <= `CRC_INIT;
            tx_len_reg <= do_exc ? `EXC_BODY_LEN : `REPLY_BODY_LEN;
          end else begin
            idx_reg <= idx_reg + 1'b1;
            crc_reg <= mb_pkg::crc_byte(crc_reg, mem[idx_reg[IW-2:0]]);
          end
        end
        mb_pkg::DEV_WR: begin
          if (wcnt_reg == reg_cnt) begin
            idx_reg <= '0;
            tx_len_reg <= any_ok ? `REPLY_BODY_LEN : `EXC_BODY_LEN;
          end else begin
            idx_reg <= idx_reg + 1'b1;
          end
        end
        mb_pkg::DEV_TX: begin
          if (tx_step && idx_reg <= tx_len_reg + 1'b1) begin
            idx_reg <= idx_reg + 1'b1;
            if (idx_reg < tx_len_reg) begin
              crc_reg <= mb_pkg::crc_byte(crc_reg, tx_byte);
            end
          end
        end
        default: idx_reg <= '0;
      endcase
    end
  end

  // one register per cycle; the register side reports acceptance
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_valid <= 1'b0;
      wr_addr <= 16'h0000;
      wr_data <= 16'h0000;
      wcnt_reg <= 16'h0000;
      any_ok_reg <= 1'b0;
    end else begin
      if (state_reg == mb_pkg::DEV_WR && wcnt_reg != reg_cnt) begin
        wr_valid <= 1'b1;
        wr_addr <= start_addr + wcnt_reg;
        wr_data <= {mem[wpos[IW-2:0]], mem[wpos[IW-2:0] + 1'b1]};
        wcnt_reg <= wcnt_reg + 1'b1;
      end else begin
        wr_valid <= 1'b0;
        if (state_reg != mb_pkg::DEV_WR) begin
          wcnt_reg <= 16'h0000;
          any_ok_reg <= 1'b0;
        end
      end
      if (wr_valid && wr_accept) begin
        any_ok_reg <= 1'b1;
      end
    end
  end

  // the register side refuses block writes to single-write registers

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.r_valid <= 1'b0;
      link.r_data <= 8'h00;
      link.r_last <= 1'b0;
    end else if (state_reg == mb_pkg::DEV_TX && tx_step) begin
      link.r_valid <= idx_reg <= tx_len_reg + 1'b1;
      link.r_data <= tx_byte;
      link.r_last <= idx_reg == tx_len_reg + 1'b1;
    end else if (state_reg != mb_pkg::DEV_TX) begin
      link.r_valid <= 1'b0;
      link.r_last <= 1'b0;
    end
  end
endmodule

// >>> core/mb_master_end.sv
// master end: builds diagnostics and multi-write queries, collects replies
`timescale 1ns/1ps
`include "mb_defs.svh"
module mb_master_end #(
  parameter int MAXW = 8,
  parameter int GAP_CYCLES = `BCAST_GAP_NS / `CLK_PERIOD_NS,
  parameter int TIMEOUT_CYCLES = `REPLY_TIMEOUT_NS / `CLK_PERIOD_NS
) (
  input wire logic ref_clk, // 40 MHz clock
  input wire logic sys_rst, // async reset, active high
  mb_link_if.mst link, // link to the drive
  input wire logic cmd_valid, // start a query
  output logic cmd_ready, // master idle
  input wire logic [7:0] cmd_station, // target station, 0 broadcast
  input wire logic cmd_write, // 1 multi-write, 0 diagnostics
  input wire logic [15:0] cmd_addr, // start address or sub-function
  input wire logic [15:0] cmd_count, // register count or echo data
  input wire logic [MAXW*16-1:0] cmd_words, // write words, word 0 lowest
  input wire logic cmd_line_err, // mark the query as line-damaged
  output logic resp_valid, // reply or timeout, one cycle
  output logic resp_timeout, // no reply arrived
  output logic resp_crc_ok, // reply crc checked good
  output logic [7:0] resp_func, // reply function byte
  output logic [15:0] resp_w1, // reply bytes 2 and 3
  output logic [15:0] resp_w2 // reply bytes 4 and 5
);
  mb_pkg::mst_state_type state_reg;
  logic [7:0] st_reg;
  logic wr_reg;
  logic [15:0] addr_reg;
  logic [15:0] cnt_reg;
  logic [MAXW*16-1:0] words_reg;
  logic lerr_reg;
  logic [8:0] pos_reg;
  logic [8:0] body_len;
  logic [15:0] crc_reg;
  logic [31:0] wait_reg;
  logic [7:0] body_byte;
  logic [8:0] dpos;
  logic [15:0] word_sel;
  logic [7:0] rsp_bytes [6];

  assign cmd_ready = state_reg == mb_pkg::MST_IDLE;
  assign body_len = wr_reg ? `WRITE_HDR_LEN - 9'h002 + {cnt_reg[7:0], 1'b0} : 9'h006;
  assign dpos = pos_reg - 9'(`POS_DATA);
  assign word_sel = words_reg[16*dpos[8:1] +: 16];
  assign link.r_ready = state_reg == mb_pkg::MST_RSP;

  // byte at the current position of the query
  always_comb begin
    case (pos_reg)
      9'(`POS_STATION): body_byte = st_reg;
      9'(`POS_FUNC): body_byte = wr_reg ? `FN_WRITE_MULTI : `FN_DIAG;
      9'(`POS_ADDR_HI): body_byte = addr_reg[15:8];
      9'(`POS_ADDR_LO): body_byte = addr_reg[7:0];
      9'(`POS_CNT_HI): body_byte = cnt_reg[15:8];
      9'(`POS_CNT_LO): body_byte = cnt_reg[7:0];
      9'(`POS_BYTE_CNT): body_byte = {cnt_reg[6:0], 1'b0};
      default: body_byte = dpos[0] ? word_sel[7:0] : word_sel[15:8];
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= mb_pkg::MST_IDLE;
      st_reg <= 8'h00;
      wr_reg <= 1'b0;
      addr_reg <= 16'h0000;
      cnt_reg <= 16'h0000;
      words_reg <= '0;
      lerr_reg <= 1'b0;
      pos_reg <= 9'h000;
      crc_reg <= `CRC_INIT;
      wait_reg <= 32'h0;
    end else begin
      case (state_reg)
        mb_pkg::MST_IDLE: begin
          pos_reg <= 9'h000;
          crc_reg <= `CRC_INIT;
          wait_reg <= 32'h0;
          if (cmd_valid) begin
            st_reg <= cmd_station;
            wr_reg <= cmd_write;
            addr_reg <= cmd_addr;
            cnt_reg <= cmd_count;
            words_reg <= cmd_words;
            lerr_reg <= cmd_line_err;
            state_reg <= mb_pkg::MST_TX;
          end
        end
        mb_pkg::MST_TX: begin
          if (link.q_ready) begin
            pos_reg <= pos_reg + 1'b1;
            if (pos_reg < body_len) begin
              crc_reg <= mb_pkg::crc_byte(crc_reg, body_byte);
            end
            if (pos_reg == body_len + 1'b1) begin
              crc_reg <= `CRC_INIT;
              pos_reg <= 9'h000;
              // broadcast write gets no reply, so just hold off
              if (wr_reg && st_reg == `STATION_BCAST) begin
                state_reg <= mb_pkg::MST_GAP;
              end else begin
                state_reg <= mb_pkg::MST_RSP;
              end
            end
          end
        end
        mb_pkg::MST_RSP: begin
          wait_reg <= wait_reg + 1'b1;
          if (link.r_valid) begin
            crc_reg <= mb_pkg::crc_byte(crc_reg, link.r_data);
            pos_reg <= pos_reg + 1'b1;
          end
          if ((link.r_valid && link.r_last) || wait_reg == 32'(TIMEOUT_CYCLES)) begin
            state_reg <= mb_pkg::MST_IDLE;
          end
        end
        mb_pkg::MST_GAP: begin
          wait_reg <= wait_reg + 1'b1;
          if (wait_reg == 32'(GAP_CYCLES)) begin
            state_reg <= mb_pkg::MST_IDLE;
          end
        end
        default: state_reg <= mb_pkg::MST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.q_valid <= 1'b0;
      link.q_data <= 8'h00;
      link.q_last <= 1'b0;
      link.q_err <= 1'b0;
    end else if (state_reg == mb_pkg::MST_TX && pos_reg <= body_len + 1'b1
                 && (!link.q_valid || link.q_ready)) begin
      link.q_valid <= 1'b1;
      if (pos_reg < body_len) begin
        link.q_data <= body_byte;
      end else if (pos_reg == body_len) begin
        link.q_data <= crc_reg[7:0];
      end else begin
        link.q_data <= crc_reg[15:8];
      end
      link.q_last <= pos_reg == body_len + 1'b1;
      link.q_err <= lerr_reg && pos_reg == body_len + 1'b1;
    end else if (link.q_ready) begin
      link.q_valid <= 1'b0;
      link.q_last <= 1'b0;
      link.q_err <= 1'b0;
    end
  end

  // keep the first six reply bytes
  always_ff @(posedge ref_clk) begin
    if (state_reg == mb_pkg::MST_RSP && link.r_valid && pos_reg < 9'h006) begin
      rsp_bytes[pos_reg[2:0]] <= link.r_data;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      resp_valid <= 1'b0;
      resp_timeout <= 1'b0;
      resp_crc_ok <= 1'b0;
      resp_func <= 8'h00;
      resp_w1 <= 16'h0000;
      resp_w2 <= 16'h0000;
    end else if (state_reg == mb_pkg::MST_RSP && link.r_valid && link.r_last) begin
      resp_valid <= 1'b1;
      resp_timeout <= 1'b0;
      resp_crc_ok <= mb_pkg::crc_byte(crc_reg, link.r_data) == 16'h0000;
      resp_func <= rsp_bytes[1];
      resp_w1 <= {rsp_bytes[2], rsp_bytes[3]};
      resp_w2 <= {rsp_bytes[4], rsp_bytes[5]};
    end else if (state_reg == mb_pkg::MST_RSP && wait_reg == 32'(TIMEOUT_CYCLES)) begin
      resp_valid <= 1'b1;
      resp_timeout <= 1'b1;
      resp_crc_ok <= 1'b0;
    end else begin
      resp_valid <= 1'b0;
    end
  end
endmodule

// >>> verif/mb_link_chk.sv
// assertions on the byte link between master end and drive end
`timescale 1ns/1ps
module mb_link_chk (
  input wire logic ref_clk, // clock
  input wire logic sys_rst, // async reset
  input wire logic q_valid, // query byte valid
  input wire logic q_ready, // drive receiving
  input wire logic [7:0] q_data, // query byte
  input wire logic q_last, // last query byte
  input wire logic q_err, // damaged byte
  input wire logic r_valid, // reply byte valid
  input wire logic r_ready, // master waiting
  input wire logic [7:0] r_data, // reply byte
  input wire logic r_last // last reply byte
);
  logic [7:0] q_mem_reg [0:7];
  logic [5:0] q_idx_reg;
  logic [3:0] r_idx_reg;
  logic bad_reg;
  logic silent_reg;
  logic norm_reg;
  wire q_take = q_valid && q_ready;
  wire r_take = r_valid && r_ready;

  always_ff @(posedge ref_clk) begin
    if (q_take && q_idx_reg < 6'h08) begin
      q_mem_reg[q_idx_reg[2:0]] <= q_data;
    end
  end

  // silence is owed from the end of a damaged or broadcast frame to the next query
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_idx_reg <= 6'h00;
      bad_reg <= 1'b0;
      silent_reg <= 1'b0;
    end else if (q_take) begin
      q_idx_reg <= q_last ? 6'h00 : q_idx_reg + 6'h01;
      bad_reg <= !q_last && (bad_reg || q_err || (q_idx_reg == 6'h00 && q_data == 8'h00));
      silent_reg <= q_last && (bad_reg || q_err);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_idx_reg <= 4'h0;
      norm_reg <= 1'b0;
    end else if (r_take) begin
      r_idx_reg <= r_last ? 4'h0 : r_idx_reg + 4'h1;
      if (r_idx_reg == 4'h1) begin
        norm_reg <= r_data == q_mem_reg[1];
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_bad_sub;
    r_take && r_idx_reg == 4'h1 && q_mem_reg[1] == 8'h08 && {q_mem_reg[2], q_mem_reg[3]} != 16'h0000;
  endsequence
  sequence s_exc_code;
    r_take && r_idx_reg == 4'h2 && r_data == 8'h03;
  endsequence

  chk_query_held: assert property (q_valid && !q_ready |=>
    q_valid && $stable(q_data) && $stable(q_last) && $stable(q_err))
    else $error("query byte changed before it was taken");
  chk_reply_held: assert property (r_valid && !r_ready |=>
    r_valid && $stable(r_data) && $stable(r_last))
    else $error("reply byte changed before it was taken");
  chk_silent_frame: assert property (silent_reg |-> !r_valid)
    else $error("reply sent to a damaged or broadcast query");
  chk_reply_station: assert property (r_take && r_idx_reg == 4'h0 |-> r_data == q_mem_reg[0])
    else $error("reply station differs from query station");
  chk_reply_func: assert property (r_take && r_idx_reg == 4'h1 |->
    r_data == q_mem_reg[1] || r_data == (q_mem_reg[1] | 8'h80))
    else $error("reply function byte wrong");
  chk_echo_fields: assert property (r_take && norm_reg && r_idx_reg inside {[2:5]} |->
    r_data == q_mem_reg[r_idx_reg[2:0]])
    else $error("normal reply field differs from query");
  chk_reply_length: assert property (r_take && r_last |->
    r_idx_reg == (norm_reg ? 4'h7 : 4'h4))
    else $error("reply length wrong");
  chk_diag_bad_sub: assert property (s_bad_sub |-> r_data == 8'h88 ##[1:4] s_exc_code)
    else $error("nonzero sub-function not answered by exception");
endmodule

// >>> verif/modbus_rtu_diag_and_multi_write_test.sv
// bench: master end and drive end joined back to back
`timescale 1ns/1ps
module modbus_rtu_diag_and_multi_write_test;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_station = 8'h00;
  logic cmd_write = 1'b0;
  logic [15:0] cmd_addr = 16'h0000;
  logic [15:0] cmd_count = 16'h0000;
  logic [127:0] cmd_words = '0;
  logic cmd_line_err = 1'b0;
  logic cmd_ready, resp_valid, resp_timeout, resp_crc_ok, wr_valid, busy, wr_accept;
  logic [7:0] resp_func;
  logic [15:0] resp_w1, resp_w2, wr_addr, wr_data;
  logic [15:0] reject_addr = 16'hFFFF;
  logic reject_all = 1'b0;
  logic [7:0] own_id = 8'h03;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_resp, n_rbytes, n_cyc;
  logic [31:0] wq [$];
  logic [7:0] qq [$];
  logic [7:0] rq [$];

  always #12.5 ref_clk = ~ref_clk;
  // refused addresses stand for registers that take only single writes
  assign wr_accept = !reject_all && (wr_addr !== reject_addr);

  mb_link_if i_mb_link_if ();
  mb_drive_end i_mb_drive_end (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(i_mb_link_if),
    .station_id(own_id), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_accept(wr_accept), .busy(busy));
  mb_master_end #(.GAP_CYCLES(50), .TIMEOUT_CYCLES(50)) i_mb_master_end (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .link(i_mb_link_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_station(cmd_station), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_count(cmd_count), .cmd_words(cmd_words), .cmd_line_err(cmd_line_err),
    .resp_valid(resp_valid), .resp_timeout(resp_timeout), .resp_crc_ok(resp_crc_ok),
    .resp_func(resp_func), .resp_w1(resp_w1), .resp_w2(resp_w2));
  mb_link_chk i_mb_link_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .q_valid(i_mb_link_if.q_valid), .q_ready(i_mb_link_if.q_ready),
    .q_data(i_mb_link_if.q_data), .q_last(i_mb_link_if.q_last), .q_err(i_mb_link_if.q_err),
    .r_valid(i_mb_link_if.r_valid), .r_ready(i_mb_link_if.r_ready),
    .r_data(i_mb_link_if.r_data), .r_last(i_mb_link_if.r_last));

  function automatic logic [15:0] crc16(input logic [7:0] b [$], input int n);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < n; i++) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic query(input logic [7:0] st, input logic wr, input logic [15:0] a,
      input logic [15:0] c, input logic le);
    n_resp = 0;
    n_rbytes = 0;
    n_cyc = 0;
    wq.delete();
    qq.delete();
    rq.delete();
    @(posedge ref_clk);
    cmd_station <= st;
    cmd_write <= wr;
    cmd_addr <= a;
    cmd_count <= c;
    cmd_line_err <= le;
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    do begin
      @(negedge ref_clk);
      n_cyc++;
    end while (cmd_ready !== 1'b1 && n_cyc < 2000);
    if (cmd_ready !== 1'b1) fail_count++;
    repeat (2) @(posedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (wr_valid === 1'b1) wq.push_back({wr_addr, wr_data});
    if (i_mb_link_if.q_valid === 1'b1 && i_mb_link_if.q_ready === 1'b1) begin
      qq.push_back(i_mb_link_if.q_data);
    end
    if (i_mb_link_if.r_valid === 1'b1 && i_mb_link_if.r_ready === 1'b1) begin
      rq.push_back(i_mb_link_if.r_data);
      n_rbytes++;
    end
    if (resp_valid === 1'b1) n_resp++;
    if (cycles == 5000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    query(own_id, 1'b0, 16'h0000, 16'h1234, 1'b0);
    check(n_resp, 1);
    check({resp_func, resp_w1, resp_w2[15:8]}, 32'h08000012);
    check(resp_w2, 16'h1234);
    check({rq[4], rq[5]}, 16'h1234);
    check({rq[7], rq[6]}, crc16(rq, 6));
    $display("test diag_echo done");
    query(own_id, 1'b0, 16'h0005, 16'h1234, 1'b0);
    check({resp_func, resp_w1[15:8]}, 16'h8803);
    $display("test diag_bad_sub done");
    cmd_words <= {96'h0, 32'h00000100};
    query(own_id, 1'b1, 16'h2102, 16'h0002, 1'b0);
    check({resp_func, resp_crc_ok}, 9'h021);
    check({resp_w1, resp_w2}, 32'h21020002);
    check(rq.size(), 8);
    check(wq.size(), 2);
    check(wq[0], 32'h21020100);
    check(wq[1], 32'h21030000);
    check({qq[2], qq[3], qq[4], qq[5]}, 32'h21020002);
    check(qq[6], 8'h04);
    check({qq[12], qq[11]}, crc16(qq, 11));
    $display("test write_pair done");
    for (int k = 0; k < 8; k++) cmd_words[16*k +: 16] <= 16'hA000 + 16'(k);
    query(8'h00, 1'b1, 16'h3000, 16'h0008, 1'b0);
    check(n_rbytes, 0);
    check(wq.size(), 8);
    for (int k = 0; k < 8; k++) check(wq[k], {16'h3000 + 16'(k), 16'hA000 + 16'(k)});
    check(n_cyc >= 50, 1);
    $display("test broadcast_write done");
    reject_addr <= 16'h3001;
    query(own_id, 1'b1, 16'h3000, 16'h0003, 1'b0);
    check(resp_func, 8'h10);
    check(wq.size(), 3);
    reject_all <= 1'b1;
    query(own_id, 1'b1, 16'h3000, 16'h0003, 1'b0);
    check({resp_func, resp_w1[15:8]}, 16'h9002);
    reject_all <= 1'b0;
    reject_addr <= 16'h3000;
    query(own_id, 1'b1, 16'h3000, 16'h0002, 1'b0);
    check(resp_func, 8'h10);
    check(wq.size(), 2);
    $display("test refused_write done");
    query(own_id, 1'b0, 16'h0000, 16'h1234, 1'b1);
    check(n_rbytes, 0);
    check(resp_timeout, 1'b1);
    check(busy, 1'b0);
    query(8'h05, 1'b0, 16'h0000, 16'h5678, 1'b0);
    check(n_rbytes, 0);
    check(resp_timeout, 1'b1);
    $display("test silent_cases done");
    give_verdict();
  end
endmodule
